// ==== verilog/bcbm_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the break matcher.
// Assumes inclusion by bare name from the design file.
`ifndef BCBM_REGS_VH
`define BCBM_REGS_VH
// ****************************************************************
// Register byte offsets on APB.
// ****************************************************************
`define BCBM_OFF_ADDR_HIGH 12'h000
`define BCBM_OFF_ADDR_LOW 12'h004
`define BCBM_OFF_MASK_HIGH 12'h008
`define BCBM_OFF_MASK_LOW 12'h00C
`define BCBM_OFF_CYCLE_SEL 12'h010
`define BCBM_OFF_CONTROL 12'h014
`define BCBM_OFF_IRQ_STATUS 12'h018
`define BCBM_OFF_IRQ_MASK 12'h01C
// ****************************************************************
// Field positions.
// ****************************************************************
`define BCBM_CS_MASTER_HI 7
`define BCBM_CS_MASTER_LO 6
`define BCBM_CS_FETCH_HI 5
`define BCBM_CS_FETCH_LO 4
`define BCBM_CS_DIR_HI 3
`define BCBM_CS_DIR_LO 2
`define BCBM_CS_SIZE_HI 1
`define BCBM_CS_SIZE_LO 0
`define BCBM_CS_WIDTH 8
`define BCBM_CR_WIDTH_HI 2
`define BCBM_CR_WIDTH_LO 1
`define BCBM_CR_IRQ_DIS 0
`define BCBM_CR_BITS 3
// ****************************************************************
// Reset values and encodings.
// ****************************************************************
`define BCBM_RST16 16'h0000
`define BCBM_SIZE_BYTE 2'h1
`define BCBM_SIZE_WORD 2'h2
`define BCBM_SIZE_LONG 2'h3
// ****************************************************************
// Trigger pulse lengths in system clocks.
// ****************************************************************
`define BCBM_PULSE_1 5'h01
`define BCBM_PULSE_4 5'h04
`define BCBM_PULSE_8 5'h08
`define BCBM_PULSE_16 5'h10
`endif

// ==== verilog/bcbm_break_matcher.v ====
// Break-condition matcher with APB register file and interrupt status.
// Assumes bus cycle inputs are valid for one mclk cycle while cycValid is high.
// Functional notes
// RULE_01: The break address is held as a high half for bits 31 to 16 and a low half for bits 15 to 0.
// RULE_02: Address, mask and cycle-select registers are 16-bit and readable and writable.
// RULE_03: These registers clear on power-on reset and module standby, and keep contents otherwise.
// RULE_04: An address bit is compared only when its mask bit is 0.
// RULE_05: Master select 00 never, 01 CPU, 10 DMA, 11 both.
// RULE_06: Access kind 00 never, 01 fetch, 10 data, 11 both.
// RULE_07: Direction 00 never, 01 read, 10 write, 11 both.
// RULE_08: Size 00 ignores size, 01 byte, 10 word, 11 longword.
// RULE_09: Cycle-select bits 15 to 8 read zero and software writes only zero there.
// RULE_10: Software breaking on fetches keeps the low size bit at 0.
// RULE_11: Every instruction fetch counts as a word access, even a double fetch.
// RULE_12: Data access size is the master's operand size, not the bus width.
// RULE_13: A match needs equal unmasked address bits and acceptance by every selection.
// RULE_14: Any of master, access kind or direction at 00 blocks every break.
// RULE_15: A match raises the break request and a trigger pulse together.
// RULE_16: Trigger pulse width is 1, 4, 8 or 16 clocks by a 2-bit field.
// RULE_17: The break request is suppressed while the disable bit is 1, which resets to 0.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "bcbm_regs.vh"

module bcbm_break_matcher (
	input wire mclk,
	input wire sys_rst,
	input wire moduleStandby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire cycValid,
	input wire [31:0] cycAddr,
	input wire cycIsDma,
	input wire cycIsFetch,
	input wire cycIsWrite,
	input wire [1:0] cycSize,
	output wire breakIrqReq,
	output wire matchTriggerOut,
	output wire irq
);

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function sel2;
		input [1:0] field;
		input firstKind;
		begin
			sel2 = firstKind ? field[0] : field[1];
		end
	endfunction

	function [15:0] laneMerge;
		input [15:0] old;
		input [15:0] wd;
		input [1:0] strb;
		begin
			laneMerge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	// Pulse length in clocks for a width code; a new pulse and a restarted one share it.
	function [4:0] pulseLen;
		input [1:0] code;
		begin
			case (code)
				2'h0: pulseLen = `BCBM_PULSE_1;
				2'h1: pulseLen = `BCBM_PULSE_4;
				2'h2: pulseLen = `BCBM_PULSE_8;
				default: pulseLen = `BCBM_PULSE_16;
			endcase
		end
	endfunction

	// Only the eight word-aligned offsets answer; any other address gets pslverr.
	function regMapped;
		input [11:0] addr;
		begin
			regMapped = 1'b0;
			if (addr == `BCBM_OFF_ADDR_HIGH)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_ADDR_LOW)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_MASK_HIGH)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_MASK_LOW)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_CYCLE_SEL)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_CONTROL)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_IRQ_STATUS)
			begin
				regMapped = 1'b1;
			end
			else if (addr == `BCBM_OFF_IRQ_MASK)
			begin
				regMapped = 1'b1;
			end
		end
	endfunction

	localparam ST_IDLE = 2'h1;
	localparam ST_PULSE = 2'h2;

	// ****************************************************************
	// Registers.
	// ****************************************************************
	reg [15:0] addrHigh_r;
	reg [15:0] addrLow_r;
	reg [15:0] maskHigh_r;
	reg [15:0] maskLow_r;
	reg [7:0] cycleSel_r;
	reg [2:0] control_r;
	reg irqStatus_r;
	reg irqMask_r;
	reg [1:0] state_r;
	reg [4:0] pulseCnt_r;
	reg [4:0] pulseCnt_nxt;
	reg [1:0] state_nxt;
	reg matchReq_r;
	reg [31:0] prdata_nxt;

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	wire clearAll = sys_rst | moduleStandby;
	wire wrEn = psel & penable & pwrite;
	wire setupPhase = psel & ~penable;
	// Write-one-to-clear of the status bit; a set in the same cycle wins over it.
	wire statusClear = wrEn && paddr == `BCBM_OFF_IRQ_STATUS && pstrb[0] && pwdata[0];
	wire [31:0] breakAddr = {addrHigh_r, addrLow_r};
	wire [31:0] addrMask = {maskHigh_r, maskLow_r};
	wire mapped = regMapped(paddr);

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Standby clears like a reset, so software must reprogram after leaving it.
	always @(posedge mclk)
	begin
		if (clearAll) // see RULE_03
		begin
			addrHigh_r <= `BCBM_RST16;
			addrLow_r <= `BCBM_RST16;
			maskHigh_r <= `BCBM_RST16;
			maskLow_r <= `BCBM_RST16;
			cycleSel_r <= 8'h00;
			control_r <= 3'h0; // see RULE_17
			irqMask_r <= 1'b0;
		end
		else if (wrEn)
		begin
			if (paddr == `BCBM_OFF_ADDR_HIGH) // see RULE_01, RULE_02
			begin
				addrHigh_r <= laneMerge(addrHigh_r, pwdata[15:0], pstrb[1:0]);
			end
			else if (paddr == `BCBM_OFF_ADDR_LOW) // see RULE_01, RULE_02
			begin
				addrLow_r <= laneMerge(addrLow_r, pwdata[15:0], pstrb[1:0]);
			end
			else if (paddr == `BCBM_OFF_MASK_HIGH) // see RULE_02
			begin
				maskHigh_r <= laneMerge(maskHigh_r, pwdata[15:0], pstrb[1:0]);
			end
			else if (paddr == `BCBM_OFF_MASK_LOW) // see RULE_02
			begin
				maskLow_r <= laneMerge(maskLow_r, pwdata[15:0], pstrb[1:0]);
			end
			else if (paddr == `BCBM_OFF_CYCLE_SEL && pstrb[0]) // see RULE_09
			begin
				cycleSel_r <= pwdata[7:0];
			end
			else if (paddr == `BCBM_OFF_CONTROL && pstrb[0])
			begin
				control_r <= pwdata[2:0];
			end
			else if (paddr == `BCBM_OFF_IRQ_MASK && pstrb[0])
			begin
				irqMask_r <= pwdata[0];
			end
		end
	end

	// ****************************************************************
	// Read path.
	// ****************************************************************
	always @*
	begin
		prdata_nxt = 32'h00000000;
		if (paddr == `BCBM_OFF_ADDR_HIGH)
		begin
			prdata_nxt = {16'h0000, addrHigh_r};
		end
		else if (paddr == `BCBM_OFF_ADDR_LOW)
		begin
			prdata_nxt = {16'h0000, addrLow_r};
		end
		else if (paddr == `BCBM_OFF_MASK_HIGH)
		begin
			prdata_nxt = {16'h0000, maskHigh_r};
		end
		else if (paddr == `BCBM_OFF_MASK_LOW)
		begin
			prdata_nxt = {16'h0000, maskLow_r};
		end
		else if (paddr == `BCBM_OFF_CYCLE_SEL)
		begin
			prdata_nxt = {24'h000000, cycleSel_r}; // see RULE_09
		end
		else if (paddr == `BCBM_OFF_CONTROL)
		begin
			prdata_nxt = {29'h0000000, control_r};
		end
		else if (paddr == `BCBM_OFF_IRQ_STATUS)
		begin
			prdata_nxt = {31'h0000000, irqStatus_r};
		end
		else if (paddr == `BCBM_OFF_IRQ_MASK)
		begin
			prdata_nxt = {31'h0000000, irqMask_r};
		end
	end

	// ****************************************************************
	// Read data register.
	// ****************************************************************
	// The word is captured in the setup cycle, so it stands unchanged through the
	// access cycle even if a match sets the status bit meanwhile.
	always @(posedge mclk)
	begin
		if (clearAll)
		begin
			prdata <= 32'h00000000;
		end
		else if (setupPhase)
		begin
			prdata <= prdata_nxt;
		end
	end

	// ****************************************************************
	// Match logic.
	// ****************************************************************
	// Fetches are always word size, whatever the bus width delivered.
	wire [1:0] effSize = cycIsFetch ? `BCBM_SIZE_WORD : cycSize; // see RULE_11, RULE_12
	wire addrHit = ((cycAddr ^ breakAddr) & ~addrMask) == 32'h00000000; // see RULE_04
	wire [1:0] sizeSel = cycleSel_r[`BCBM_CS_SIZE_HI:`BCBM_CS_SIZE_LO];
	wire [1:0] widthCode = control_r[`BCBM_CR_WIDTH_HI:`BCBM_CR_WIDTH_LO];
	wire masterOk = sel2(cycleSel_r[`BCBM_CS_MASTER_HI:`BCBM_CS_MASTER_LO], ~cycIsDma); // see RULE_05
	wire kindOk = sel2(cycleSel_r[`BCBM_CS_FETCH_HI:`BCBM_CS_FETCH_LO], cycIsFetch); // see RULE_06
	wire dirOk = sel2(cycleSel_r[`BCBM_CS_DIR_HI:`BCBM_CS_DIR_LO], ~cycIsWrite); // see RULE_07
	wire sizeOk = (sizeSel == 2'h0) || (sizeSel == effSize); // see RULE_08
	// A zero field leaves its sel2 term low, which alone blocks the match.
	wire match = cycValid & addrHit & masterOk & kindOk & dirOk & sizeOk; // see RULE_13, RULE_14

	// ****************************************************************
	// Request, trigger pulse and interrupt status.
	// ****************************************************************
	always @*
	begin
		state_nxt = state_r;
		pulseCnt_nxt = pulseCnt_r;
		case (state_r)
			ST_IDLE:
			begin
				if (match) // see RULE_15
				begin
					state_nxt = ST_PULSE;
					pulseCnt_nxt = pulseLen(widthCode); // see RULE_16
				end
			end
			ST_PULSE:
			begin
				pulseCnt_nxt = pulseCnt_r - 5'h01;
				// A match on the last cycle starts a fresh pulse, so no request goes out alone.
				if (pulseCnt_r == 5'h01 && match) // see RULE_15
				begin
					pulseCnt_nxt = pulseLen(widthCode); // see RULE_16
				end
				else if (pulseCnt_r == 5'h01)
				begin
					state_nxt = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
				pulseCnt_nxt = 5'h00;
			end
		endcase
	end

	// Matches during a running pulse do not stretch it, except on its last cycle.
	always @(posedge mclk)
	begin
		if (clearAll)
		begin
			state_r <= ST_IDLE;
			pulseCnt_r <= 5'h00;
			matchReq_r <= 1'b0;
			irqStatus_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			pulseCnt_r <= pulseCnt_nxt;
			matchReq_r <= match & ~control_r[`BCBM_CR_IRQ_DIS]; // see RULE_17
			// Set wins over a write-one clear in the same cycle.
			if (match)
			begin
				irqStatus_r <= 1'b1;
			end
			else if (statusClear)
			begin
				irqStatus_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign breakIrqReq = matchReq_r; // see RULE_15
	assign matchTriggerOut = state_r[1]; // see RULE_15
	assign irq = irqStatus_r & irqMask_r;

endmodule // bcbm_break_matcher

// ==== testbench/bcbm_bus_master_model.sv ====
// Model of the CPU and DMA masters that present bus cycles to the matcher.
// Assumes the bench pulses go for one mclk cycle for each bus cycle it wants shown.
`timescale 1ns/1ps
module bcbm_bus_master_model (
	input wire mclk,
	input wire go,
	input wire [36:0] req,
	output reg cycValid = 1'b0,
	output reg [31:0] cycAddr = 32'h0,
	output reg cycIsDma = 1'b0,
	output reg cycIsFetch = 1'b0,
	output reg cycIsWrite = 1'b0,
	output reg [1:0] cycSize = 2'h0
);
	// Idle lines flip every cycle, so a stale cycle can never pass for a fresh one.
	always @(posedge mclk)
	begin
		cycValid <= go;
		if (go)
			{cycIsDma, cycIsFetch, cycIsWrite, cycSize, cycAddr} <= req;
		else
			{cycIsDma, cycIsFetch, cycIsWrite, cycSize, cycAddr} <= ~{cycIsDma, cycIsFetch,
				cycIsWrite, cycSize, cycAddr};
	end
endmodule // bcbm_bus_master_model

// ==== testbench/bcbm_break_matcher_monitor.sv ====
// Assertion checker for the break matcher, bound to its top ports.
// Assumes one clock, mclk, and the synchronous active-high reset sys_rst.
`timescale 1ns/1ps
module bcbm_break_matcher_monitor (
	input wire mclk,
	input wire sys_rst,
	input wire moduleStandby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire cycValid,
	input wire breakIrqReq,
	input wire matchTriggerOut,
	input wire irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence s_acc;
		psel && penable;
	endsequence
	property p_reqTrig;
		breakIrqReq |-> matchTriggerOut;
	endproperty
	a_reqTrig: assert property (p_reqTrig) else $error("req no trig");
	property p_reqCause;
		breakIrqReq |-> $past(cycValid);
	endproperty
	a_reqCause: assert property (p_reqCause) else $error("req no cycle");
	property p_trigCause;
		$rose(matchTriggerOut) |-> $past(cycValid);
	endproperty
	a_trigCause: assert property (p_trigCause) else $error("trig no cycle");
	property p_selZero;
		s_acc ##0 (!pwrite && paddr == 12'h010) |-> prdata[31:8] == 24'h0;
	endproperty
	a_selZero: assert property (p_selZero) else $error("reserved set");
	property p_unmapped;
		s_acc ##0 (paddr > 12'h01C) |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_rst;
		disable iff (1'b0) sys_rst |=> !breakIrqReq && !matchTriggerOut && !irq;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_standby;
		moduleStandby |=> !breakIrqReq && !matchTriggerOut && !irq;
	endproperty
	a_standby: assert property (p_standby) else $error("standby");
	property p_irqSrc;
		$rose(irq) |-> matchTriggerOut || $past(psel && penable && pwrite);
	endproperty
	a_irqSrc: assert property (p_irqSrc) else $error("irq no cause");
endmodule // bcbm_break_matcher_monitor
bind bcbm_break_matcher bcbm_break_matcher_monitor mon_u (.mclk(mclk), .sys_rst(sys_rst),
	.moduleStandby(moduleStandby), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr), .cycValid(cycValid),
	.breakIrqReq(breakIrqReq), .matchTriggerOut(matchTriggerOut), .irq(irq));

// ==== testbench/bcbm_break_matcher_bench.sv ====
// Bench for the break matcher: APB master tasks, a table of bus cycles, then edge cases.
// Assumes a match is flagged one cycle after the bus cycle; every APB wait is bounded.
`timescale 1ns/1ps
module bcbm_break_matcher_bench;
	localparam logic [31:0] A = 32'h12345678;
	logic mclk, sys_rst, moduleStandby, psel, penable, pwrite, go, err, pready, pslverr;
	logic cycValid, cycIsDma, cycIsFetch, cycIsWrite, breakIrqReq, matchTriggerOut, irq;
	logic [1:0] cycSize;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, cycAddr;
	logic [36:0] req;
	logic [15:0] vals [0:3] = '{16'h1234, 16'h5678, 16'h0, 16'h000F};
	int wid [0:3] = '{1, 4, 8, 16};
	int n_errors = 0;
	int compares = 0;
	int i, k;
	logic [45:0] rows [0:13] = '{
		{8'h54, 3'h2, 2'h2, A, 1'h1}, {8'h54, 3'h6, 2'h2, A, 1'h0},
		{8'h94, 3'h6, 2'h2, A, 1'h1}, {8'hD4, 3'h2, 2'h2, A, 1'h1},
		{8'h64, 3'h2, 2'h2, A, 1'h0}, {8'h68, 3'h1, 2'h1, A, 1'h1},
		{8'h7C, 3'h0, 2'h1, 32'h1234567D, 1'h1}, {8'h7C, 3'h0, 2'h1, 32'h12345668, 1'h0},
		{8'h7D, 3'h0, 2'h1, A, 1'h1}, {8'h7E, 3'h2, 2'h3, A, 1'h1},
		{8'h7F, 3'h0, 2'h2, A, 1'h0}, {8'h3C, 3'h0, 2'h1, A, 1'h0},
		{8'h4C, 3'h0, 2'h1, A, 1'h0}, {8'h70, 3'h0, 2'h1, A, 1'h0}};
	bcbm_break_matcher dut_u (.mclk(mclk), .sys_rst(sys_rst), .moduleStandby(moduleStandby),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycValid(cycValid),
		.cycAddr(cycAddr), .cycIsDma(cycIsDma), .cycIsFetch(cycIsFetch), .cycIsWrite(cycIsWrite),
		.cycSize(cycSize), .breakIrqReq(breakIrqReq), .matchTriggerOut(matchTriggerOut), .irq(irq));
	bcbm_bus_master_model bm_u (.mclk(mclk), .go(go), .req(req), .cycValid(cycValid),
		.cycAddr(cycAddr), .cycIsDma(cycIsDma), .cycIsFetch(cycIsFetch),
		.cycIsWrite(cycIsWrite), .cycSize(cycSize));
	task stop_test();
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		for (k = 0; k < 9 && pready !== 1'b1; k++)
			@(posedge mclk);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		chkb(pready, 1'b1);
		if (pready !== 1'b1)
			stop_test();
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task cyc(input logic [36:0] r);
		@(posedge mclk);
		{go, req} <= {1'b1, r};
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		sys_rst = 1'b1;
		{moduleStandby, psel, penable, pwrite, go, paddr, pwdata, req} = 86'h0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		for (i = 0; i < 8; i++)
			rdc(12'(4 * i), 32'h0);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, 12'(4 * i), {16'hFFFF, vals[i]});
			rdc(12'(4 * i), {16'h0, vals[i]});
		end
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		rdc(12'h010, 32'hFF);
		apb(1'b1, 12'h01C, 32'h1);
		for (i = 0; i < 14; i++)
		begin
			apb(1'b1, 12'h010, {24'h0, rows[i][45:38]});
			cyc(rows[i][37:1]);
			chkb(breakIrqReq, rows[i][0]);
			chkb(matchTriggerOut, rows[i][0]);
		end
		repeat (2) @(negedge mclk);
		chkb(irq, 1'b1);
		apb(1'b1, 12'h01C, 32'h0);
		repeat (2) @(negedge mclk);
		chkb(irq, 1'b0);
		rdc(12'h018, 32'h1);
		apb(1'b1, 12'h018, 32'h1);
		rdc(12'h018, 32'h0);
		apb(1'b1, 12'h010, 32'h54);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, 12'h014, {29'h0, 2'(i), 1'b1});
			cyc(rows[0][37:1]);
			chkb(breakIrqReq, 1'b0);
			repeat (wid[i] - 1) @(negedge mclk);
			chkb(matchTriggerOut, 1'b1);
			@(negedge mclk);
			chkb(matchTriggerOut, 1'b0);
		end
		apb(1'b1, 12'h014, 32'h0);
		@(posedge mclk);
		{go, req} <= {1'b1, rows[0][37:1]};
		repeat (2) @(posedge mclk);
		go <= 1'b0;
		repeat (2) @(negedge mclk);
		chkb(breakIrqReq, 1'b1);
		chkb(matchTriggerOut, 1'b1);
		@(negedge mclk);
		chkb(matchTriggerOut, 1'b0);
		@(posedge mclk);
		moduleStandby <= 1'b1;
		@(posedge mclk);
		moduleStandby <= 1'b0;
		rdc(12'h000, 32'h0);
		apb(1'b1, 12'h004, 32'h00005678);
		@(posedge mclk);
		sys_rst <= 1'b1;
		@(posedge mclk);
		sys_rst <= 1'b0;
		rdc(12'h004, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chkb(err, 1'b1);
		chk(rd, 32'h0);
		stop_test();
	end
endmodule // bcbm_break_matcher_bench
